/* File: rtl/anpsr_regs.sv */
// Auto-negotiation link partner ability and expansion status registers
// Functional notes
// - The partner ability word is read-only, bit 15 is partner next page and bit 14 its ack.
// - Bits 11 to 5 show partner asym pause, pause, T4, TX FD, TX, 10 FD and 10 abilities.
// - The partner selector decodes 00001 as 802.3, 00010 as 802.9, 00000 and 11111 reserved.
// - Expansion bit 5 latches high on base page receipt, meaningful with alternate mode.
// - Expansion bit 4 latches high on a parallel detection fault.
// - Expansion bit 3 shows partner next page ability.
// - Expansion bit 2 shows local next page ability and resets to one.
// - Page received latches on a new page; base pages load the ability word, next pages 8.
// - A read of the expansion register clears page received.
// - In alternate mode page received also clears on page_rx low or transmit disable high.
// - Expansion bit 0 shows partner autoneg ability and bits 15 to 6 read zero.
`timescale 1ns/1ps
`include "anpsr_consts.svh"
module anpsr_regs
  import anpsr_pkg::*;
(
  input  wire logic        CLK_SYS,          // System clock, 50 MHz
  input  wire logic        RST_N,            // Synchronous reset, active low
  input  wire anpsr_page_s PAGE_IN,          // Received code word from arbitration
  input  wire logic        PAR_DET_FAULT,    // Parallel detection fault event
  input  wire logic        LP_AN_ABLE,       // Partner is autoneg able
  input  wire logic        MR_PAGE_RX,       // Arbitration page received variable
  input  wire logic        TRANSMIT_DISABLE, // Arbitration transmit disable variable
  input  wire logic        ALT_NP_MODE,      // alternate_next_page_mode control bit
  input  wire anpsr_rd_s   RD_REQ,           // Management read request
  output anpsr_word_t      RD_DATA,          // Read data, valid the cycle after request
  output logic             RD_VALID,         // Read data valid pulse
  output anpsr_sel_e       LP_SEL_DECODE     // Decoded partner selector
);
  // ----------------------------------------------------------------
  // Received page storage
  // ----------------------------------------------------------------
  anpsr_word_t ability_ff;
  anpsr_word_t nxt_ability;
  anpsr_word_t np_rx_ff;
  anpsr_word_t nxt_np_rx;
  logic        local_np_ff;
  logic        nxt_local_np;

  always_comb
  begin
    nxt_ability  = ability_ff;
    nxt_np_rx    = np_rx_ff;
    nxt_local_np = local_np_ff;
    if (PAGE_IN.page_valid)
    begin
      if (PAGE_IN.page_is_next)
      begin
        nxt_np_rx = PAGE_IN.code_word;
      end
      else
      begin
        nxt_ability = PAGE_IN.code_word;
        // Reserved bit never stored, so it always reads back as zero
        nxt_ability[`ANPSR_ABL_RSV_BIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      ability_ff  <= `ANPSR_ABILITY_RST;
      np_rx_ff    <= `ANPSR_NP_RX_RST;
      local_np_ff <= `ANPSR_LOCAL_NP_RST;
    end
    else
    begin
      ability_ff  <= nxt_ability;
      np_rx_ff    <= nxt_np_rx;
      local_np_ff <= nxt_local_np;
    end
  end

  // ----------------------------------------------------------------
  // Selector decode
  // ----------------------------------------------------------------
  // Decoded from the next ability word so that the registered result
  // changes on the same edge as the stored selector
  logic [4:0] sel_field;
  anpsr_sel_e sel_decode_ff;
  anpsr_sel_e nxt_sel_decode;

  assign sel_field = nxt_ability[`ANPSR_ABL_SEL_HI:`ANPSR_ABL_SEL_LO];

  always_comb
  begin
    unique case (sel_field)
      `ANPSR_SEL_8023:   nxt_sel_decode = ANPSR_SEL_IEEE8023;
      `ANPSR_SEL_8029:   nxt_sel_decode = ANPSR_SEL_IEEE8029;
      `ANPSR_SEL_RSV_LO: nxt_sel_decode = ANPSR_SEL_RESERVED;
      `ANPSR_SEL_RSV_HI: nxt_sel_decode = ANPSR_SEL_RESERVED;
      default:           nxt_sel_decode = ANPSR_SEL_UNSPEC;
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      sel_decode_ff <= ANPSR_SEL_RESERVED;
    end
    else
    begin
      sel_decode_ff <= nxt_sel_decode;
    end
  end

  assign LP_SEL_DECODE = sel_decode_ff;

  // ----------------------------------------------------------------
  // Clear conditions
  // ----------------------------------------------------------------
  logic rd_exp;
  logic alt_clr;
  logic pr_clr;

  // A read of the expansion word clears every flag that it holds
  assign rd_exp  = RD_REQ.rd_strobe && (RD_REQ.addr == `ANPSR_ADDR_EXPANSION);
  // Level clear, applied on every cycle while alternate mode holds it true
  assign alt_clr = ALT_NP_MODE && (!MR_PAGE_RX || TRANSMIT_DISABLE);
  assign pr_clr  = rd_exp || alt_clr;

  // ----------------------------------------------------------------
  // Latching-high flags
  // ----------------------------------------------------------------
  // Set wins over clear inside each flag, so no event is lost to a read
  logic base_rx_evt;
  logic new_page_evt;
  logic base_flag;
  logic pdf_flag;
  logic pr_flag;

  assign base_rx_evt  = PAGE_IN.page_valid && !PAGE_IN.page_is_next;
  assign new_page_evt = PAGE_IN.page_valid;

  anpsr_latch_flag u_base_flag
  (
    .CLK_SYS (CLK_SYS),
    .RST_N   (RST_N),
    .SET     (base_rx_evt),
    .CLR     (rd_exp),
    .FLAG    (base_flag)
  );

  anpsr_latch_flag u_pdf_flag
  (
    .CLK_SYS (CLK_SYS),
    .RST_N   (RST_N),
    .SET     (PAR_DET_FAULT),
    .CLR     (rd_exp),
    .FLAG    (pdf_flag)
  );

  anpsr_latch_flag u_pr_flag
  (
    .CLK_SYS (CLK_SYS),
    .RST_N   (RST_N),
    .SET     (new_page_evt),
    .CLR     (pr_clr),
    .FLAG    (pr_flag)
  );

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  anpsr_word_t exp_word;
  anpsr_word_t rd_data_ff;
  anpsr_word_t nxt_rd_data;
  logic        rd_valid_ff;
  logic        nxt_rd_valid;

  always_comb
  begin
    // Live partner ability bit, latched flags and bits of stored words
    exp_word = 16'h0000;
    exp_word[`ANPSR_EXP_BASE_BIT] = base_flag;
    exp_word[`ANPSR_EXP_PDF_BIT]  = pdf_flag;
    exp_word[`ANPSR_EXP_LPNP_BIT] = ability_ff[`ANPSR_ABL_NP_BIT];
    exp_word[`ANPSR_EXP_NPA_BIT]  = local_np_ff;
    exp_word[`ANPSR_EXP_PR_BIT]   = pr_flag;
    exp_word[`ANPSR_EXP_LPAN_BIT] = LP_AN_ABLE;
  end

  always_comb
  begin
    // Snapshot taken at the request edge, held until the next read
    nxt_rd_valid = RD_REQ.rd_strobe;
    nxt_rd_data  = rd_data_ff;
    if (RD_REQ.rd_strobe)
    begin
      unique case (RD_REQ.addr)
        `ANPSR_ADDR_ABILITY:   nxt_rd_data = ability_ff;
        `ANPSR_ADDR_EXPANSION: nxt_rd_data = exp_word;
        `ANPSR_ADDR_NP_RX:     nxt_rd_data = np_rx_ff;
        default:               nxt_rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      rd_data_ff  <= 16'h0000;
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_data_ff  <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  assign RD_DATA  = rd_data_ff;
  assign RD_VALID = rd_valid_ff;
endmodule : anpsr_regs

/* File: rtl/anpsr_consts.svh */
// Register offsets, field positions and reset values of the partner status registers
`ifndef ANPSR_CONSTS_SVH
`define ANPSR_CONSTS_SVH
`define ANPSR_ADDR_ABILITY   5'h05
`define ANPSR_ADDR_EXPANSION 5'h06
`define ANPSR_ADDR_NP_RX     5'h08
`define ANPSR_ABL_NP_BIT     15
`define ANPSR_ABL_ACK_BIT    14
`define ANPSR_ABL_RF_BIT     13
`define ANPSR_ABL_RSV_BIT    12
`define ANPSR_ABL_TECH_HI    11
`define ANPSR_ABL_TECH_LO    5
`define ANPSR_ABL_SEL_HI     4
`define ANPSR_ABL_SEL_LO     0
`define ANPSR_EXP_BASE_BIT   5
`define ANPSR_EXP_PDF_BIT    4
`define ANPSR_EXP_LPNP_BIT   3
`define ANPSR_EXP_NPA_BIT    2
`define ANPSR_EXP_PR_BIT     1
`define ANPSR_EXP_LPAN_BIT   0
`define ANPSR_ABILITY_RST    16'h0000
`define ANPSR_NP_RX_RST      16'h0000
`define ANPSR_LOCAL_NP_RST   1'h1
`define ANPSR_SEL_8023       5'h01
`define ANPSR_SEL_8029       5'h02
`define ANPSR_SEL_RSV_LO     5'h00
`define ANPSR_SEL_RSV_HI     5'h1f
`endif

/* File: rtl/anpsr_pkg.sv */
// Types shared by the partner status register bank
package anpsr_pkg;
  typedef logic [15:0] anpsr_word_t;

  typedef enum logic [1:0] {
    ANPSR_SEL_IEEE8023,
    ANPSR_SEL_IEEE8029,
    ANPSR_SEL_RESERVED,
    ANPSR_SEL_UNSPEC
  } anpsr_sel_e;

  typedef struct packed {
    logic        page_valid;
    logic        page_is_next;
    anpsr_word_t code_word;
  } anpsr_page_s;

  typedef struct packed {
    logic        rd_strobe;
    logic [4:0]  addr;
  } anpsr_rd_s;
endpackage : anpsr_pkg

/* File: rtl/anpsr_latch_flag.sv */
// Latching-high flag cleared by a register read, set wins over clear
`timescale 1ns/1ps
module anpsr_latch_flag
  import anpsr_pkg::*;
(
  input  wire logic CLK_SYS,    // System clock
  input  wire logic RST_N,      // Synchronous reset, active low
  input  wire logic SET,        // Event that latches the flag
  input  wire logic CLR,        // Read or other clear condition
  output logic      FLAG        // Latched flag
);
  logic flag_ff;
  logic nxt_flag;

  always_comb
  begin
    nxt_flag = flag_ff;
    if (CLR)
    begin
      nxt_flag = 1'b0;
    end
    if (SET)
    begin
      nxt_flag = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      flag_ff <= 1'b0;
    end
    else
    begin
      flag_ff <= nxt_flag;
    end
  end

  assign FLAG = flag_ff;
endmodule : anpsr_latch_flag

/* File: dv/anpsr_regs_sva.sv */
// Checker of the partner status register bank
`timescale 1ns/1ps
module anpsr_regs_sva
  import anpsr_pkg::*;
(
  input wire logic        CLK_SYS,       // Clock
  input wire logic        RST_N,         // Reset, active low
  input wire anpsr_page_s PAGE_IN,       // Page from partner
  input wire logic        PAR_DET_FAULT, // Fault event
  input wire logic        LP_AN_ABLE,    // Partner autoneg able
  input wire logic        ALT_NP_MODE,   // Alternate mode
  input wire anpsr_rd_s   RD_REQ,        // Read request
  input wire anpsr_word_t RD_DATA,       // Read data
  input wire logic        RD_VALID       // Read valid
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  logic rd6;
  assign rd6 = RD_REQ.rd_strobe && RD_REQ.addr == 5'h06;
  sequence s_base;
    PAGE_IN.page_valid && !PAGE_IN.page_is_next;
  endsequence
  sequence s_rd5;
    RD_REQ.rd_strobe && RD_REQ.addr == 5'h05 && !PAGE_IN.page_valid;
  endsequence
  a_rd_answer: assert property (RD_REQ.rd_strobe |=> RD_VALID)
    else $error("read not answered");
  a_rd_single: assert property (!RD_REQ.rd_strobe |=> !RD_VALID)
    else $error("stray read valid");
  a_base_store: assert property (
    s_base ##1 s_rd5 |=> RD_DATA == ($past(PAGE_IN.code_word, 2) & 16'hefff))
    else $error("base page not stored");
  a_page_latch: assert property (s_base ##1 rd6 |=> RD_DATA[1] && RD_DATA[5])
    else $error("page flags not set");
  a_read_clear: assert property (
    (rd6 && !PAGE_IN.page_valid && !PAR_DET_FAULT) ##1 rd6 |=> RD_DATA[5:4] == 2'h0 && !RD_DATA[1])
    else $error("flags not cleared by read");
  a_fault_latch: assert property (PAR_DET_FAULT ##1 rd6 |=> RD_DATA[4])
    else $error("fault flag not set");
  a_exp_fixed: assert property (
    rd6 |=> RD_DATA[15:6] == 10'h0 && RD_DATA[2] && RD_DATA[0] == $past(LP_AN_ABLE))
    else $error("expansion fixed bits wrong");
  a_flag_hold: assert property (
    s_base ##1 (!rd6 && !ALT_NP_MODE)[*3] ##1 rd6 |=> RD_DATA[1])
    else $error("page flag lost");
endmodule : anpsr_regs_sva
bind anpsr_regs anpsr_regs_sva u_anpsr_regs_sva(.CLK_SYS, .RST_N, .PAGE_IN, .PAR_DET_FAULT,
  .LP_AN_ABLE, .ALT_NP_MODE, .RD_REQ, .RD_DATA, .RD_VALID);

/* File: dv/anpsr_link_partner.sv */
// Remote link partner model delivering received pages
`timescale 1ns/1ps
module anpsr_link_partner
  import anpsr_pkg::*;
(
  input  wire logic   CLK_SYS,  // Clock
  output anpsr_page_s PAGE_OUT  // Page toward the register bank
);
  initial PAGE_OUT = '0;
  task automatic send(input logic nxt, input anpsr_word_t w);
    @(posedge CLK_SYS);
    PAGE_OUT <= '{1'b1, nxt, w};
    @(posedge CLK_SYS);
    PAGE_OUT <= '{1'b0, 1'b0, ~w};
    #1;
  endtask : send
endmodule : anpsr_link_partner

/* File: dv/test_anpsr_regs.sv */
// Testbench of the partner status register bank
`timescale 1ns/1ps
module test_anpsr_regs;
  import anpsr_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, pdf = 1'b0, lpan = 1'b1;
  logic        page_rx = 1'b0, tx_dis = 1'b0, alt = 1'b0, rd_valid;
  anpsr_rd_s   rd = '0;
  anpsr_page_s page;
  anpsr_word_t rd_data;
  anpsr_sel_e  sel;
  anpsr_sel_e  sel_exp[4] = '{ANPSR_SEL_IEEE8023, ANPSR_SEL_IEEE8029, ANPSR_SEL_RESERVED,
                              ANPSR_SEL_UNSPEC};
  logic [4:0]  codes[4] = '{5'h01, 5'h02, 5'h1f, 5'h03};
  int          error_cnt = 0, n_compared = 0, cyc = 0;
  always #10 clk = ~clk;
  anpsr_link_partner u_anpsr_link_partner(.CLK_SYS(clk), .PAGE_OUT(page));
  anpsr_regs u_anpsr_regs(.CLK_SYS(clk), .RST_N(rst_n), .PAGE_IN(page), .PAR_DET_FAULT(pdf),
    .LP_AN_ABLE(lpan), .MR_PAGE_RX(page_rx), .TRANSMIT_DISABLE(tx_dis), .ALT_NP_MODE(alt),
    .RD_REQ(rd), .RD_DATA(rd_data), .RD_VALID(rd_valid), .LP_SEL_DECODE(sel));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd_late(input int n, input logic [4:0] a, input anpsr_word_t exp);
    repeat (n) @(posedge clk);
    rd <= '{1'b1, a};
    @(posedge clk);
    rd <= '{1'b0, a};
    #1 check({15'h0, rd_valid}, 16'h0001);
    check(rd_data, exp);
  endtask : rd_late
  task automatic rd_chk(input logic [4:0] a, input anpsr_word_t exp);
    rd_late(1, a, exp);
  endtask : rd_chk
  task automatic rd_two(input logic [4:0] a, input anpsr_word_t exp0, input anpsr_word_t exp1);
    @(posedge clk);
    rd <= '{1'b1, a};
    @(posedge clk);
    #1 check(rd_data, exp0);
    @(posedge clk);
    rd <= '{1'b0, a};
    #1 check(rd_data, exp1);
    check({15'h0, rd_valid}, 16'h0001);
  endtask : rd_two
  task automatic t_reset;
    rd_chk(5'h05, 16'h0000);
    rd_chk(5'h06, 16'h0005);
    rd_chk(5'h08, 16'h0000);
    rd_chk(5'h09, 16'h0000);
    check({14'h0, sel}, {14'h0, ANPSR_SEL_RESERVED});
  endtask : t_reset
  task automatic t_sel;
    for (int i = 0; i < 4; i++)
    begin
      u_anpsr_link_partner.send(1'b0, {11'h0, codes[i]});
      check({14'h0, sel}, {14'h0, sel_exp[i]});
    end
    rd_chk(5'h05, 16'h0003);
    rd_chk(5'h06, 16'h0027);
  endtask : t_sel
  task automatic t_next;
    u_anpsr_link_partner.send(1'b1, 16'h5a5a);
    rd_chk(5'h08, 16'h5a5a);
    rd_chk(5'h05, 16'h0003);
    rd_chk(5'h06, 16'h0007);
  endtask : t_next
  task automatic t_base;
    u_anpsr_link_partner.send(1'b0, 16'hffff);
    repeat (3) @(posedge clk);
    rd_chk(5'h05, 16'hefff);
    rd_chk(5'h06, 16'h002f);
    rd_chk(5'h06, 16'h000d);
  endtask : t_base
  task automatic t_fault_alt;
    @(posedge clk);
    pdf <= 1'b1;
    @(posedge clk);
    pdf <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(5'h06, 16'h001d);
    rd_chk(5'h06, 16'h000d);
    u_anpsr_link_partner.send(1'b0, 16'h8000);
    @(posedge clk);
    alt <= 1'b1;
    @(posedge clk);
    alt <= 1'b0;
    rd_chk(5'h06, 16'h002d);
    u_anpsr_link_partner.send(1'b0, 16'h8000);
    @(posedge clk);
    page_rx <= 1'b1;
    alt <= 1'b1;
    tx_dis <= 1'b1;
    @(posedge clk);
    alt <= 1'b0;
    tx_dis <= 1'b0;
    rd_chk(5'h06, 16'h002d);
  endtask : t_fault_alt
  task automatic t_timing;
    fork
      u_anpsr_link_partner.send(1'b0, 16'h1c21);
      rd_late(2, 5'h05, 16'h0c21);
    join
    check({14'h0, sel}, {14'h0, ANPSR_SEL_IEEE8023});
    fork
      u_anpsr_link_partner.send(1'b0, 16'h8421);
      rd_late(2, 5'h06, 16'h002f);
    join
    u_anpsr_link_partner.send(1'b0, 16'h8421);
    rd_two(5'h06, 16'h002f, 16'h000d);
    fork
      begin
        @(posedge clk);
        pdf <= 1'b1;
        @(posedge clk);
        pdf <= 1'b0;
      end
      rd_late(2, 5'h06, 16'h001d);
    join
    fork
      u_anpsr_link_partner.send(1'b0, 16'h0021);
      rd_late(5, 5'h06, 16'h0027);
    join
    fork
      u_anpsr_link_partner.send(1'b0, 16'h0021);
      rd_late(1, 5'h06, 16'h0005);
    join
    rd_chk(5'h06, 16'h0027);
  endtask : t_timing
  task automatic t_alt_hold;
    @(posedge clk);
    alt <= 1'b1;
    u_anpsr_link_partner.send(1'b0, 16'h0021);
    rd_chk(5'h06, 16'h0027);
    @(posedge clk);
    alt <= 1'b0;
    lpan <= 1'b0;
    rd_chk(5'h06, 16'h0004);
    @(posedge clk);
    lpan <= 1'b1;
  endtask : t_alt_hold
  task automatic t_mid_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check(rd_data, 16'h0000);
    check({15'h0, rd_valid}, 16'h0000);
    @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
  endtask : t_mid_reset
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      close_out;
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_sel;
    t_next;
    t_base;
    t_fault_alt;
    t_timing;
    t_alt_hold;
    t_mid_reset;
    close_out;
  end
endmodule : test_anpsr_regs
